// file: pkg/aip_pkg.sv
// package for the identify parameter block: task-file map, fixed words, types
// assumes a single 20 MHz clock domain shared by all users
package aip_pkg;

    // task-file register offsets
    localparam logic [2:0] OFS_DATA    = 3'h0;
    localparam logic [2:0] OFS_FEATURE = 3'h1;
    localparam logic [2:0] OFS_SECCNT  = 3'h2;
    localparam logic [2:0] OFS_SECNUM  = 3'h3;
    localparam logic [2:0] OFS_CYLLO   = 3'h4;
    localparam logic [2:0] OFS_CYLHI   = 3'h5;
    localparam logic [2:0] OFS_DRVHD   = 3'h6;
    localparam logic [2:0] OFS_COMMAND = 3'h7;

    // command opcode and drive-select bit position
    localparam logic [7:0] CMD_IDENTIFY = 8'hec;
    localparam int         DRV_BIT      = 4;

    // status bits of the read-back status register
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ERR_ABORT = 8'h04;

    // block geometry
    localparam logic [7:0] LAST_WORD = 8'hff;
    localparam int         FIFO_W    = 16;
    localparam int         FIFO_D    = 16;

    // fixed identify words
    localparam logic [15:0] W_GENCFG = 16'h044a;
    localparam logic [15:0] W_MULTI  = 16'h8001;
    localparam logic [15:0] W_CAPAB  = 16'h0b00;
    localparam logic [15:0] W_PIOMD  = 16'h0200;
    localparam logic [15:0] W_VALID  = 16'h0007;
    localparam logic [7:0]  W59_HI   = 8'h01;
    localparam logic [7:0]  W63_LO   = 8'h07;
    localparam logic [15:0] W_APIO   = 16'h0003;
    localparam logic [15:0] W_CYCLE  = 16'h0078;
    localparam logic [15:0] W_MAJOR  = 16'h00fe;
    localparam logic [15:0] W_MINOR  = 16'h0021;
    localparam logic [15:0] W_FEAT0  = 16'h706b;
    localparam logic [15:0] W_FEAT1  = 16'h7408;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // host task-file access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } aip_tf_req_type;

    // configuration words supplied by the controller
    typedef struct packed {
        logic [15:0]  def_cyl;
        logic [15:0]  def_head;
        logic [15:0]  def_spt;
        logic [31:0]  total_sect;
        logic [15:0]  cur_cyl;
        logic [15:0]  cur_head;
        logic [15:0]  cur_spt;
        logic [31:0]  cur_cap;
        logic [7:0]   multi_set;
        logic [31:0]  lba_sect;
        logic [7:0]   dma_sel;
        logic [79:0]  serial_user;
        logic [79:0]  unique_id;
        logic [63:0]  fw_rev;
        logic [319:0] model;
    } aip_cfg_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILL = 2'b01,
        ST_DONE = 2'b11
    } aip_state_type;

endpackage

// file: rtl/aip_fifo.sv
// small synchronous FIFO carrying parameter words toward the data register
// assumes push and pop come from logic on the same clock
`timescale 1ns/10ps
module aip_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_reg;
    logic [AW:0]      rp_reg;
    logic             push;
    logic             pop;

    // honest full and empty from the pointer pair
    assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
    assign out_valid = wp_reg != rp_reg;
    assign out_data  = mem[rp_reg[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers
    always_ff @(posedge clk) begin
        if (!rst_b || (ce && flush)) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (ce) begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (ce && push) mem[wp_reg[AW-1:0]] <= in_data;
    end
endmodule

// file: rtl/aip_identify.sv
// task-file command decode and identify parameter block source
// assumes the host task-file strobes are already synchronous to clk
`timescale 1ns/10ps

// Notes on behaviour
// - block goes out through the sector-read style data-in handshake
// - reserved words and reserved bits read as zero
// - task-file registers used only when valid for the command
// - identify decodes only the drive-select bit, never the head field
// - words 0, 49, 51 read 044a, 0b00, 0200
// - word 53 reads 0007
// - words 1, 3, 6 carry default geometry; 2, 4, 5 zero
// - words 7 and 8 hold total sectors, high half first
// - words 10 to 14 return the user serial string
// - words 15 to 19 return the preset unique identifier
// - words 23 to 26 hold firmware revision, first character high byte
// - words 27 to 46 return the forty-byte model string
// - word 47 reads 8001
// - words 54 to 56 reflect the current geometry
// - words 57 and 58 hold current capacity, low half first
// - word 59 is 01 over multiple setting; words 60-61 hold lba sectors
// - word 63 low byte 07, high byte the selected dma mode
// - word 64 reads 0003
// - words 65 to 68 read 0078
// - words 80 to 83 read 00fe, 0021, 706b, 7408
module aip_identify (
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    // task-file access
    input  wire aip_pkg::aip_tf_req_type tf_req,
    output logic [15:0]               tf_rdata,
    // device identity and configuration
    input  wire logic                 dev_num,
    input  wire aip_pkg::aip_cfg_type cfg,
    // status
    output logic                      drq,
    output logic                      busy,
    output logic                      cmd_done
);

    // ****************************************
    // word lookup
    // ****************************************

    // pick one 16-bit word out of a packed string, first word at the top
    function automatic logic [15:0] str_word(input logic [319:0] s, input int idx,
                                             input int nwords);
        str_word = s[(nwords-1-idx)*16 +: 16];
    endfunction

    // parameter word for a given index; unlisted words are zero
    function automatic logic [15:0] id_word(input logic [7:0] w,
                                            input aip_pkg::aip_cfg_type c);
        logic [319:0] ser;
        logic [319:0] uid;
        logic [319:0] fw;
        ser = {240'h0, c.serial_user};
        uid = {240'h0, c.unique_id};
        fw  = {256'h0, c.fw_rev};
        id_word = aip_pkg::RST_WORD;
        case (w) inside
            8'd0:  id_word = aip_pkg::W_GENCFG;
            8'd1:  id_word = c.def_cyl;
            8'd3:  id_word = c.def_head;
            8'd6:  id_word = c.def_spt;
            8'd7:  id_word = c.total_sect[31:16];
            8'd8:  id_word = c.total_sect[15:0];
            [8'd10:8'd14]: id_word = str_word(ser, int'(w) - 10, 5);
            [8'd15:8'd19]: id_word = str_word(uid, int'(w) - 15, 5);
            [8'd23:8'd26]: id_word = str_word(fw, int'(w) - 23, 4);
            [8'd27:8'd46]: id_word = str_word(c.model, int'(w) - 27, 20);
            8'd47: id_word = aip_pkg::W_MULTI;
            8'd49: id_word = aip_pkg::W_CAPAB;
            8'd51: id_word = aip_pkg::W_PIOMD;
            8'd53: id_word = aip_pkg::W_VALID;
            8'd54: id_word = c.cur_cyl;
            8'd55: id_word = c.cur_head;
            8'd56: id_word = c.cur_spt;
            8'd57: id_word = c.cur_cap[15:0];
            8'd58: id_word = c.cur_cap[31:16];
            8'd59: id_word = {aip_pkg::W59_HI, c.multi_set};
            8'd60: id_word = c.lba_sect[15:0];
            8'd61: id_word = c.lba_sect[31:16];
            8'd63: id_word = {c.dma_sel, aip_pkg::W63_LO};
            8'd64: id_word = aip_pkg::W_APIO;
            [8'd65:8'd68]: id_word = aip_pkg::W_CYCLE;
            8'd80: id_word = aip_pkg::W_MAJOR;
            8'd81: id_word = aip_pkg::W_MINOR;
            8'd82: id_word = aip_pkg::W_FEAT0;
            8'd83: id_word = aip_pkg::W_FEAT1;
            default: id_word = aip_pkg::RST_WORD;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************

    typedef struct packed {
        aip_pkg::aip_state_type st;
        logic [7:0]  feature_param_reg;
        logic [7:0]  sector_count_reg;
        logic [7:0]  sector_number_reg;
        logic [15:0] cylinder_regs;
        logic [7:0]  drive_head_reg;
        logic [7:0]  error_reg;
        logic [7:0]  fill_idx;
        logic [7:0]  read_cnt;
        logic        drq;
        logic        busy;
        logic        done;
        logic [15:0] rdata;
    } aip_core_type;

    aip_core_type core_reg;
    aip_core_type core_next;

    logic        f_in_ready;
    logic        f_out_valid;
    logic [15:0] f_out_data;
    logic        f_push;
    logic        data_rd;
    logic        cmd_wr;
    logic        sel_match;

    // host read of the data register while the block is on offer
    assign data_rd   = tf_req.rd && tf_req.addr == aip_pkg::OFS_DATA && core_reg.drq;
    assign cmd_wr    = tf_req.wr && tf_req.addr == aip_pkg::OFS_COMMAND;
    // only the drive bit matters for identify, head field disregarded
    assign sel_match = core_reg.drive_head_reg[aip_pkg::DRV_BIT] == dev_num;
    assign f_push    = core_reg.st == aip_pkg::ST_FILL;

    // ****************************************
    // word buffer
    // ****************************************

    aip_fifo #(
        .WIDTH (aip_pkg::FIFO_W),
        .DEPTH (aip_pkg::FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .flush     (cmd_wr),
        .in_valid  (f_push),
        .in_ready  (f_in_ready),
        .in_data   (id_word(core_reg.fill_idx, cfg)),
        .out_valid (f_out_valid),
        // pop at the read edge itself, so back-to-back reads each get a fresh word
        .out_ready (data_rd),
        .out_data  (f_out_data)
    );

    // ****************************************
    // next-state logic
    // ****************************************

    always_comb begin
        core_next      = core_reg;
        core_next.done = 1'b0;
        // parameter registers are only stored; identify consumes only the drive bit of the drive/head register
        if (tf_req.wr) begin
            case (tf_req.addr)
                aip_pkg::OFS_FEATURE: core_next.feature_param_reg = tf_req.wdata;
                aip_pkg::OFS_SECCNT:  core_next.sector_count_reg  = tf_req.wdata;
                aip_pkg::OFS_SECNUM:  core_next.sector_number_reg = tf_req.wdata;
                aip_pkg::OFS_CYLLO:   core_next.cylinder_regs[7:0]  = tf_req.wdata;
                aip_pkg::OFS_CYLHI:   core_next.cylinder_regs[15:8] = tf_req.wdata;
                aip_pkg::OFS_DRVHD:   core_next.drive_head_reg    = tf_req.wdata;
                default: ;
            endcase
        end
        // register read-back mux
        case (tf_req.addr)
            aip_pkg::OFS_DATA:    core_next.rdata = core_reg.drq ? f_out_data : '0;
            aip_pkg::OFS_FEATURE: core_next.rdata = {8'h00, core_reg.error_reg};
            aip_pkg::OFS_SECCNT:  core_next.rdata = {8'h00, core_reg.sector_count_reg};
            aip_pkg::OFS_SECNUM:  core_next.rdata = {8'h00, core_reg.sector_number_reg};
            aip_pkg::OFS_CYLLO:   core_next.rdata = {8'h00, core_reg.cylinder_regs[7:0]};
            aip_pkg::OFS_CYLHI:   core_next.rdata = {8'h00, core_reg.cylinder_regs[15:8]};
            aip_pkg::OFS_DRVHD:   core_next.rdata = {8'h00, core_reg.drive_head_reg};
            default: core_next.rdata = {8'h00, core_reg.busy, ~core_reg.busy, 2'b00,
                                        core_reg.drq, 2'b00, core_reg.error_reg != '0};
        endcase
        // command decode: identify for this drive starts a block
        if (cmd_wr) begin
            core_next.drq      = 1'b0;
            core_next.fill_idx = '0;
            core_next.read_cnt = '0;
            if (tf_req.wdata == aip_pkg::CMD_IDENTIFY && sel_match) begin
                core_next.st        = aip_pkg::ST_FILL;
                core_next.busy      = 1'b1;
                core_next.error_reg = aip_pkg::RST_BYTE;
            end else begin
                core_next.st        = aip_pkg::ST_IDLE;
                core_next.busy      = 1'b0;
                core_next.error_reg = aip_pkg::ERR_ABORT;
                core_next.done      = 1'b1;
            end
        end else begin
            case (core_reg.st)
                aip_pkg::ST_FILL: begin
                    // words pushed in ascending order, back-pressured by the fifo
                    if (f_in_ready) begin
                        core_next.fill_idx = core_reg.fill_idx + 8'h01;
                        if (core_reg.fill_idx == aip_pkg::LAST_WORD)
                            core_next.st = aip_pkg::ST_DONE;
                    end
                    // data-in handshake: drq once a word is waiting
                    if (f_out_valid) begin
                        core_next.drq  = 1'b1;
                        core_next.busy = 1'b0;
                    end
                end
                aip_pkg::ST_DONE: begin
                    if (f_out_valid) begin
                        core_next.drq  = 1'b1;
                        core_next.busy = 1'b0;
                    end
                end
                aip_pkg::ST_IDLE: ;
                default: core_next.st = aip_pkg::ST_IDLE;
            endcase
            // each data read takes one word; after the last, drq drops
            if (data_rd) begin
                core_next.read_cnt = core_reg.read_cnt + 8'h01;
                if (core_reg.read_cnt == aip_pkg::LAST_WORD) begin
                    core_next.drq  = 1'b0;
                    core_next.st   = aip_pkg::ST_IDLE;
                    core_next.done = 1'b1;
                end
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_reg <= '{st: aip_pkg::ST_IDLE, default: '0};
        end else if (ce) begin
            core_reg <= core_next;
        end
    end

    // outputs straight from flops
    assign tf_rdata = core_reg.rdata;
    assign drq      = core_reg.drq;
    assign busy     = core_reg.busy;
    assign cmd_done = core_reg.done;

    // ****************************************
    // checks
    // ****************************************

    sequence s_ident_cmd;
        ce && cmd_wr && tf_req.wdata == aip_pkg::CMD_IDENTIFY && sel_match;
    endsequence

    a_ident_start: assert property (@(posedge clk) disable iff (!rst_b)
        s_ident_cmd |=> busy && !drq && core_reg.st == aip_pkg::ST_FILL)
        else $error("identify did not start");

    a_drive_only: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && tf_req.wdata == aip_pkg::CMD_IDENTIFY && !sel_match
        |=> !busy && core_reg.error_reg == aip_pkg::ERR_ABORT)
        else $error("wrong drive accepted");

    a_drq_rise: assert property (@(posedge clk) disable iff (!rst_b)
        s_ident_cmd ##1 (ce && !cmd_wr)[*4] |=> drq)
        else $error("data request late");

    a_first_word: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(drq) |-> f_out_data == aip_pkg::W_GENCFG)
        else $error("first word wrong");

    a_fill_order: assert property (@(posedge clk) disable iff (!rst_b)
        ce && f_push && f_in_ready && !cmd_wr && core_reg.fill_idx != aip_pkg::LAST_WORD
        |=> core_reg.fill_idx == $past(core_reg.fill_idx) + 8'h01)
        else $error("fill order broken");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && (core_reg.fill_idx == 8'd2 || core_reg.fill_idx == 8'd62
                   || core_reg.fill_idx > 8'd83)
        |-> id_word(core_reg.fill_idx, cfg) == '0)
        else $error("reserved word not zero");

    a_valid_word: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd53 |-> id_word(8'd53, cfg) == aip_pkg::W_VALID)
        else $error("word 53 wrong");

    a_cap_order: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd57 |-> id_word(8'd57, cfg) == cfg.cur_cap[15:0])
        else $error("capacity order wrong");

    a_block_end: assert property (@(posedge clk) disable iff (!rst_b)
        ce && data_rd && !cmd_wr && core_reg.read_cnt == aip_pkg::LAST_WORD
        |=> !drq && cmd_done)
        else $error("block end wrong");

    // a refused command ends at once with the done pulse and no data request
    a_abort_done: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_wr && !(tf_req.wdata == aip_pkg::CMD_IDENTIFY && sel_match)
        |=> cmd_done && !busy && !drq)
        else $error("abort not completed");

    a_idle_zero: assert property (@(posedge clk) disable iff (!rst_b)
        ce && tf_req.rd && tf_req.addr == aip_pkg::OFS_DATA && !drq |=> tf_rdata == '0)
        else $error("idle data not zero");

    a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        ce && tf_req.rd && tf_req.addr == aip_pkg::OFS_COMMAND
        |=> tf_rdata[aip_pkg::ST_DRQ] == $past(drq) && tf_rdata[aip_pkg::ST_BSY] == $past(busy))
        else $error("status bits wrong");

    a_busy_excl: assert property (@(posedge clk) disable iff (!rst_b)
        !(busy && drq))
        else $error("busy with data request");

    a_done_single: assert property (@(posedge clk) disable iff (!rst_b)
        ce && cmd_done && !cmd_wr |=> !cmd_done)
        else $error("done pulse too long");

    // fixed and split fields land in their words in the agreed order
    a_gencfg_word: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd0 |-> id_word(8'd0, cfg) == aip_pkg::W_GENCFG)
        else $error("word 0 wrong");

    a_total_order: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd7 |-> id_word(8'd7, cfg) == cfg.total_sect[31:16])
        else $error("total sectors order wrong");

    a_serial_first: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd10 |-> id_word(8'd10, cfg) == cfg.serial_user[79:64])
        else $error("serial order wrong");

    a_unique_first: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd15 |-> id_word(8'd15, cfg) == cfg.unique_id[79:64])
        else $error("unique id order wrong");

    a_fw_first: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd23 |-> id_word(8'd23, cfg) == cfg.fw_rev[63:48])
        else $error("firmware order wrong");

    a_model_last: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd46 |-> id_word(8'd46, cfg) == cfg.model[15:0])
        else $error("model order wrong");

    a_dma_word: assert property (@(posedge clk) disable iff (!rst_b)
        f_push && core_reg.fill_idx == 8'd63
        |-> id_word(8'd63, cfg) == {cfg.dma_sel, aip_pkg::W63_LO})
        else $error("word 63 wrong");
endmodule

// file: testbench/aip_host_model.sv
// task-file host model: single-cycle read and write strobes on the device bus
// assumes the device takes a strobe at a rising edge and answers after that edge
`timescale 1ns/10ps
module aip_host_model (
    // clock
    input  wire logic               clk,
    // task-file bus
    output aip_pkg::aip_tf_req_type tf_req,
    input  wire logic [15:0]        tf_rdata
);
    // bus idle at time zero
    initial tf_req = '0;

    // one write strobe; released lines then carry the inverse of the last value
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        tf_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        tf_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // one read strobe; data is taken once the accepting edge has landed
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] q);
        @(posedge clk);
        tf_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        tf_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        q = tf_rdata;
    endtask
endmodule

// file: testbench/tb_aip_identify.sv
// self-checking bench for the identify parameter block
// assumes the host model above drives the task-file bus
`timescale 1ns/10ps
module tb_aip_identify;
    // ****************************************
    // signals
    // ****************************************
    logic                    clk;
    logic                    rst_b;
    logic                    ce;
    logic                    dev_num;
    aip_pkg::aip_tf_req_type tf_req;
    logic [15:0]             tf_rdata;
    aip_pkg::aip_cfg_type    cfg;
    logic                    drq;
    logic                    busy;
    logic                    cmd_done;
    logic [15:0]             q;
    int                      bad_count;
    int                      comparisons;

    aip_identify i_aip_identify (.clk(clk), .rst_b(rst_b), .ce(ce), .tf_req(tf_req),
        .tf_rdata(tf_rdata), .dev_num(dev_num), .cfg(cfg), .drq(drq), .busy(busy),
        .cmd_done(cmd_done));
    aip_host_model i_aip_host_model (.clk(clk), .tf_req(tf_req), .tf_rdata(tf_rdata));

    // ****************************************
    // helpers
    // ****************************************
    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // expected parameter word worked out from the configuration
    function automatic logic [15:0] exp_word(input int n);
        case (n) inside
            0: return 16'h044a;
            1: return cfg.def_cyl;
            3: return cfg.def_head;
            6: return cfg.def_spt;
            7: return cfg.total_sect[31:16];
            8: return cfg.total_sect[15:0];
            [10:14]: return cfg.serial_user[16*(14-n) +: 16];
            [15:19]: return cfg.unique_id[16*(19-n) +: 16];
            [23:26]: return cfg.fw_rev[16*(26-n) +: 16];
            [27:46]: return cfg.model[16*(46-n) +: 16];
            47: return 16'h8001;
            49: return 16'h0b00;
            51: return 16'h0200;
            53: return 16'h0007;
            54: return cfg.cur_cyl;
            55: return cfg.cur_head;
            56: return cfg.cur_spt;
            57: return cfg.cur_cap[15:0];
            58: return cfg.cur_cap[31:16];
            59: return {8'h01, cfg.multi_set};
            60: return cfg.lba_sect[15:0];
            61: return cfg.lba_sect[31:16];
            63: return {cfg.dma_sel, 8'h07};
            64: return 16'h0003;
            [65:68]: return 16'h0078;
            80: return 16'h00fe;
            81: return 16'h0021;
            82: return 16'h706b;
            83: return 16'h7408;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded wait for a flag; a hang ends the run
    task automatic wait_high(ref logic s);
        for (int i = 0; i < 20; i++) begin
            #1;
            if (s === 1'b1) return;
            @(posedge clk);
        end
        bad_count++;
        report_and_stop();
    endtask

    // select a drive and issue a command
    task automatic issue(input logic [7:0] dh, input logic [7:0] op);
        i_aip_host_model.wr_reg(aip_pkg::OFS_DRVHD, dh);
        i_aip_host_model.wr_reg(aip_pkg::OFS_COMMAND, op);
    endtask

    // read words in order, with a short clock-enable pause mid-block
    task automatic read_block(input int count);
        wait_high(drq);
        // status shows ready with data request, not busy
        i_aip_host_model.rd_reg(aip_pkg::OFS_COMMAND, q);
        check("status drq", q, 16'h0048);
        for (int n = 0; n < count; n++) begin
            i_aip_host_model.rd_reg(aip_pkg::OFS_DATA, q);
            check($sformatf("word %0d", n), q, exp_word(n));
            if (n == 100) begin
                @(posedge clk);
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                check("drq frozen", {15'h0, drq}, 16'h0001);
                ce <= 1'b1;
            end
        end
    endtask

    // completion after the last word, looked at in the cycle the pulse stands
    task automatic finish_check();
        check("drq end", {15'h0, drq}, 16'h0000);
        check("done pulse", {15'h0, cmd_done}, 16'h0001);
        @(posedge clk);
        #1;
        check("done once", {15'h0, cmd_done}, 16'h0000);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        dev_num = 1'b0;
        bad_count = 0;
        comparisons = 0;
        cfg = '{def_cyl: 16'h03c2, def_head: 16'h0010, def_spt: 16'h003f,
                total_sect: 32'h000e_c2f0, cur_cyl: 16'h01e1, cur_head: 16'h000f,
                cur_spt: 16'h0020, cur_cap: 32'h0003_8700, multi_set: 8'h01,
                lba_sect: 32'h0012_3456, dma_sel: 8'h04, serial_user: "USER-SER01",
                unique_id: "UID0000042", fw_rev: "FW1.00AB",
                model: "0123456789abcdefghijklmnopqrstuvwxyzABCD"};
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        // data read with no transfer pending returns zero
        i_aip_host_model.rd_reg(aip_pkg::OFS_DATA, q);
        check("idle data", q, 16'h0000);
        // junk in unused parameters, head field set, drive 0
        for (int a = 1; a < 6; a++) i_aip_host_model.wr_reg(a[2:0], 8'h5a ^ a[7:0]);
        // a stored parameter reads back unchanged
        i_aip_host_model.rd_reg(aip_pkg::OFS_SECCNT, q);
        check("sector count", q, 16'h0058);
        issue(8'hef, aip_pkg::CMD_IDENTIFY);
        read_block(256);
        finish_check();
        // wrong drive, then a command other than identify: both aborted
        for (int k = 0; k < 2; k++) begin
            issue(k == 0 ? 8'hb0 : 8'ha0, k == 0 ? aip_pkg::CMD_IDENTIFY : 8'h20);
            wait_high(cmd_done);
            check("abort busy", {14'h0, busy, drq}, 16'h0000);
            i_aip_host_model.rd_reg(aip_pkg::OFS_FEATURE, q);
            check("abort error", q, 16'h0004);
            i_aip_host_model.rd_reg(aip_pkg::OFS_COMMAND, q);
            check("abort status", q, 16'h0041);
        end
        // drive 1 selected; restart mid-block starts again at word 0
        @(posedge clk);
        dev_num <= 1'b1;
        issue(8'h1f, aip_pkg::CMD_IDENTIFY);
        read_block(5);
        issue(8'h1f, aip_pkg::CMD_IDENTIFY);
        read_block(256);
        finish_check();
        report_and_stop();
    end
endmodule
